//--- verilog/rmirq_consts.svh
// constants for the reset mode latch and external interrupt block
// Behaviour
// - while reset is asserted, hold reset state and reinitialise the phase generator.
// - on reset release, sample four mode pins into the operating mode register.
// - the four mode pins form one 4-bit code choosing one of 16 modes.
// - after reset release, the four pins act as interrupt request lines.
// - each interrupt input is maskable at o_irq_req (the mask does not gate o_wake) and level or falling-edge triggered.
// - interrupt a asserted in stop or wait makes the processor leave standby.
// - interrupts b, c or d asserted in wait make the processor leave wait.
`ifndef RMIRQ_CONSTS_SVH
`define RMIRQ_CONSTS_SVH
`define RMIRQ_NUM_LINES 4
`define RMIRQ_MODE_RST 4'h0
`define RMIRQ_LINE_A 0
`define RMIRQ_PHASE_RST 2'h0
`endif

//--- verilog/rmirq_pkg.sv
// types for the reset mode latch and external interrupt block
package rmirq_pkg;
    typedef logic [3:0] rmirq_vec_t;
    typedef enum logic [2:0]
    {
        RMIRQ_ST_RESET = 3'h1,
        RMIRQ_ST_LATCH = 3'h2,
        RMIRQ_ST_RUN = 3'h4
    } rmirq_state_e;
    typedef struct packed
    {
        rmirq_vec_t mask;
        rmirq_vec_t edge_mode;
        rmirq_vec_t service;
    } rmirq_cfg_s;
    typedef struct packed
    {
        logic stop;
        logic wait_st;
    } rmirq_standby_s;
endpackage

//--- verilog/rmirq_line.sv
// one interrupt request line: synchroniser, edge capture, level path
`include "rmirq_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module rmirq_line
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic i_req_b,
    input wire logic i_edge_mode,
    input wire logic i_service,
    output logic o_active,
    output logic o_pend
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic pend;
    } line_s;
    line_s q;
    line_s d;
    always_comb
    begin
        d = q;
        // idle level fed in outside run so the mode code is never seen as a request
        d.s1 = i_run ? i_req_b : 1'b1;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (!i_run)
        begin
            d.pend = 1'b0;
        end
        else if (i_edge_mode && q.s3 && !q.s2)
        begin
            d.pend = 1'b1;
        end
        else if (i_service)
        begin
            d.pend = 1'b0;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, pend: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end
    assign o_active = i_run && (i_edge_mode ? q.pend : !q.s2);
    assign o_pend = q.pend;
    edge_set_wins_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_run && i_edge_mode && q.s3 && !q.s2) |=> q.pend)
        else $error("falling edge not recorded as pending");
    pend_holds_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (q.pend && i_run && !i_service) |=> q.pend)
        else $error("pending request dropped without service");
endmodule
`default_nettype wire

//--- verilog/rmirq_top.sv
// reset mode latch and four external interrupt request lines
`include "rmirq_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module rmirq_top
    import rmirq_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_mode_select_in_a,
    input wire logic i_mode_select_in_b,
    input wire logic i_mode_select_in_c,
    input wire logic i_mode_select_in_d,
    input wire rmirq_cfg_s i_cfg,
    input wire rmirq_standby_s i_standby,
    output logic [3:0] o_op_mode,
    output logic o_mode_valid,
    output logic [1:0] o_phase,
    output logic o_in_reset,
    output logic [3:0] o_irq_req,
    output logic [3:0] o_irq_pend,
    output logic o_wake
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed
    {
        rmirq_state_e st;
        rmirq_vec_t mode;
        logic [1:0] phase;
    } top_s;
    top_s q;
    top_s d;
    rmirq_vec_t pins;
    rmirq_vec_t active;
    rmirq_vec_t pend;
    logic run;
    assign pins = {i_mode_select_in_d, i_mode_select_in_c, i_mode_select_in_b, i_mode_select_in_a};
    assign run = (q.st == RMIRQ_ST_RUN);
    always_comb
    begin
        d = q;
        d.phase = q.phase + 2'h1;
        unique case (q.st)
            RMIRQ_ST_RESET:
            begin
                d.mode = pins;
                d.st = RMIRQ_ST_LATCH;
            end
            RMIRQ_ST_LATCH:
            begin
                d.st = RMIRQ_ST_RUN;
            end
            RMIRQ_ST_RUN:
            begin
                d.st = RMIRQ_ST_RUN;
            end
            default:
            begin
                d.st = RMIRQ_ST_RESET;
            end
        endcase
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q <= '{st: RMIRQ_ST_RESET, mode: `RMIRQ_MODE_RST, phase: `RMIRQ_PHASE_RST};
        end
        else
        begin
            q <= d;
        end
    end
    // ----------------------------------------
    // interrupt lines
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `RMIRQ_NUM_LINES; g++)
        begin : g_line
            rmirq_line u_line
            (
                .i_clk_sys(i_clk_sys),
                .i_rst_b(i_rst_b),
                .i_run(run),
                .i_req_b(pins[g]),
                .i_edge_mode(i_cfg.edge_mode[g]),
                .i_service(i_cfg.service[g]),
                .o_active(active[g]),
                .o_pend(pend[g])
            );
        end
    endgenerate
    assign o_irq_req = active & ~i_cfg.mask;
    assign o_irq_pend = pend;
    assign o_wake = (active[`RMIRQ_LINE_A] && (i_standby.stop || i_standby.wait_st))
        || ((|active[3:1]) && i_standby.wait_st);
    assign o_op_mode = q.mode;
    assign o_mode_valid = run;
    assign o_phase = q.phase;
    assign o_in_reset = (q.st == RMIRQ_ST_RESET);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    mode_latched_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (q.st == RMIRQ_ST_RESET) |=> (o_op_mode == $past(pins)))
        else $error("mode not latched at reset release");
    mode_stable_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        run |=> $stable(o_op_mode))
        else $error("mode changed after reset");
    run_after_two_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_in_reset |=> ##1 o_mode_valid)
        else $error("interrupt mode not entered");
    no_req_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !run |-> (o_irq_req == 4'h0))
        else $error("request during reset");
    mask_gates_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ((o_irq_req & i_cfg.mask) == 4'h0))
        else $error("masked request seen");
    level_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (run && !i_cfg.edge_mode[1] && !i_cfg.mask[1] && !pins[1]) ##1 !i_cfg.edge_mode[1] && !i_cfg.mask[1]
        ##1 !i_cfg.edge_mode[1] && !i_cfg.mask[1] |-> o_irq_req[1] || $past(pins[1]) != 1'b0)
        else $error("level request missing");
    wake_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (active[0] && i_standby.stop) |-> o_wake)
        else $error("no wake from stop");
    wake_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (|active[3:1] && i_standby.wait_st) |-> o_wake)
        else $error("no wake from wait");
    no_stop_bcd_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (!active[0] && !i_standby.wait_st) |-> !o_wake)
        else $error("wrong wake source");
    phase_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        $rose(o_mode_valid) |-> (o_phase == 2'h2))
        else $error("phase not reinitialised");
    in_reset_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_in_reset |=> !o_in_reset)
        else $error("reset state kept after release");
    phase_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        1'b1 |=> (o_phase == ($past(o_phase) + 2'h1)))
        else $error("phase generator not counting");
    pend_off_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !o_mode_valid |-> (o_irq_pend == 4'h0))
        else $error("pending request outside run");
    cov_run: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_mode_valid));
    cov_level: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_irq_req[1] && !i_cfg.edge_mode[1]);
    cov_edge: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) $rose(o_irq_pend[0]));
    cov_wake_stop: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_wake && i_standby.stop);
    cov_wake_wait: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_wake && active[3]);
endmodule
`default_nettype wire

//--- tb/rmirq_src.sv
// model of the reset circuit and interrupt sources
`timescale 1ns/10ps
`default_nettype none
module rmirq_src
(
    input wire logic i_clk_sys,
    input wire logic i_hold_rst,
    input wire logic [3:0] i_mode,
    input wire logic [3:0] i_req,
    output logic o_rst_b,
    output logic [3:0] o_pin
);
    logic held_q = 1'b1;
    // reset driven from power-up until the bench lets go
    assign o_rst_b = !i_hold_rst;
    always_ff @(posedge i_clk_sys)
        held_q <= i_hold_rst;
    // mode code held past the latching edge, then active-low requests
    assign o_pin = (i_hold_rst || held_q) ? i_mode : ~i_req;
endmodule
`default_nettype wire

//--- tb/rmirq_top_bench.sv
// self-checking bench for the reset mode latch and interrupt block
`timescale 1ns/10ps
`default_nettype none
module rmirq_top_bench;
    import rmirq_pkg::*;
    logic clk = 1'b0, hold = 1'b1, rst_b, wake, valid, in_rst;
    logic [3:0] mode = 4'h0, req = 4'h0, pin, op_mode, irq, pend;
    logic [1:0] phase;
    rmirq_cfg_s cfg = '0;
    rmirq_standby_s sb = '0;
    int n_fail = 0, n_compared = 0, cyc = 0;
    rmirq_src i_src (.i_clk_sys(clk), .i_hold_rst(hold), .i_mode(mode), .i_req(req), .o_rst_b(rst_b), .o_pin(pin));
    rmirq_top i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_mode_select_in_a(pin[0]), .i_mode_select_in_b(pin[1]),
        .i_mode_select_in_c(pin[2]), .i_mode_select_in_d(pin[3]), .i_cfg(cfg), .i_standby(sb),
        .o_op_mode(op_mode), .o_mode_valid(valid), .o_phase(phase), .o_in_reset(in_rst),
        .o_irq_req(irq), .o_irq_pend(pend), .o_wake(wake));
    // ---------------------------------
    // shared tasks
    // ---------------------------------
    task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ---------------------------------
    // scenarios
    // ---------------------------------
    task automatic reset_mode(input logic [3:0] code);
        hold = 1'b1;
        mode = code;
        tick(10);
        chk("in_reset", {3'h0, in_rst}, 4'h1);
        chk("phase", {2'h0, phase}, 4'h0);
        chk("valid_rst", {3'h0, valid}, 4'h0);
        chk("irq_rst", irq, 4'h0);
        hold = 1'b0;
        tick(1);
        chk("op_mode", op_mode, code);
        chk("in_reset_off", {3'h0, in_rst}, 4'h0);
        chk("phase_run", {2'h0, phase}, 4'h1);
        tick(1);
        chk("valid_run", {3'h0, valid}, 4'h1);
        chk("op_mode_kept", op_mode, code);
        chk("irq_idle", irq, 4'h0);
    endtask
    task automatic level_req(input int k);
        cfg = '0;
        req = 4'(4'h1 << k);
        tick(2);
        chk("level_req", irq, req);
        cfg.mask = req;
        tick(1);
        chk("masked_req", irq, 4'h0);
        req = 4'h0;
        cfg = '0;
        tick(3);
        chk("level_gone", irq, 4'h0);
    endtask
    task automatic edge_req(input int k);
        cfg = '0;
        cfg.edge_mode = 4'hf;
        req = 4'(4'h1 << k);
        tick(3);
        chk("pend_set", pend, req);
        chk("edge_req", irq, req);
        req = 4'h0;
        tick(3);
        chk("pend_held", pend, 4'(4'h1 << k));
        cfg.service = 4'hf;
        tick(1);
        cfg.service = 4'h0;
        tick(1);
        chk("pend_clear", pend, 4'h0);
    endtask
    task automatic wake_chk(input logic stp, input logic [3:0] r, input logic exp);
        cfg = '0;
        sb.stop = stp;
        sb.wait_st = !stp;
        req = r;
        tick(3);
        chk("wake", {3'h0, wake}, {3'h0, exp});
        req = 4'h0;
        sb = '0;
        tick(3);
    endtask
    // ---------------------------------
    // clock, timeout, main sequence
    // ---------------------------------
    initial
    begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        for (int c = 0; c < 16; c++)
            reset_mode(4'(c));
        for (int k = 0; k < 4; k++)
        begin
            level_req(k);
            edge_req(k);
        end
        wake_chk(1'b1, 4'h1, 1'b1);
        wake_chk(1'b0, 4'h1, 1'b1);
        wake_chk(1'b1, 4'h2, 1'b0);
        for (int k = 1; k < 4; k++)
            wake_chk(1'b0, 4'(4'h1 << k), 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
